// File: src/uic_pkg.sv
// Constants shared by the USB device init/config register block.
// Assumes a 200 MHz system clock and byte-wide command codes.
package uic_pkg;

	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [7:0] UIC_CMD_EPCFG_WR = 8'h20;
	localparam logic [7:0] UIC_CMD_EPCFG_RD = 8'h30;
	localparam logic [7:0] UIC_CMD_ADDR_WR = 8'hB6;
	localparam logic [7:0] UIC_CMD_ADDR_RD = 8'hB7;
	localparam logic [7:0] UIC_CMD_MODE_WR = 8'hB8;
	localparam logic [7:0] UIC_CMD_MODE_RD = 8'hB9;
	localparam logic [7:0] UIC_CMD_HWCFG_WR = 8'hBA;
	localparam logic [7:0] UIC_CMD_HWCFG_RD = 8'hBB;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int UIC_EP_BUF_EN = 7;
	localparam int UIC_EP_DIR = 6;
	localparam int UIC_EP_DBL = 5;
	localparam int UIC_EP_ISO = 4;
	localparam int UIC_ADDR_DEV_EN = 7;
	localparam int UIC_MODE_SUSP = 5;
	localparam int UIC_MODE_GIE = 3;
	localparam int UIC_MODE_DBG = 2;
	localparam int UIC_MODE_PULLUP = 0;
	localparam int UIC_HW_EXT_PULL = 14;
	localparam int UIC_HW_NO_SLOW = 13;
	localparam int UIC_HW_CLK_ON = 12;
	localparam int UIC_HW_DIV_LSB = 8;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] UIC_EPCFG_RST = 8'h00;
	localparam logic [7:0] UIC_ADDR_RST = 8'h00;
	localparam logic [7:0] UIC_MODE_RST = 8'h80;
	localparam logic [15:0] UIC_HWCFG_RST = 16'h2344;
	localparam logic [15:0] UIC_HWCFG_WMASK = 16'h7FEB;
	localparam logic [7:0] UIC_MODE_WMASK = 8'hFF;
	localparam int UIC_NUM_EP = 16;
	localparam logic [3:0] UIC_LAST_EP = 4'hF;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int UIC_CLK_MHZ = 200;
	localparam int UIC_SUSP_DELAY_US = 2000;
	localparam int UIC_SUSP_DELAY_CYC = UIC_SUSP_DELAY_US * UIC_CLK_MHZ;
	// Half period of the 48 MHz reference in system cycles, set to
	// one whole cycle (100 MHz) since 200 MHz cannot make 48 MHz exactly
	localparam int UIC_REF_HALF_CYC = 1;
	// Slow suspend clock, about 110 kHz: half period of 909 cycles
	localparam int UIC_SLOW_HALF_CYC = 909;

	typedef enum {UIC_AL_IDLE, UIC_AL_RUN} uic_alloc_st_t;

endpackage : uic_pkg

// File: src/uic_clock_output_pin.sv
// Clock output pin generator with divider and slow suspend clock.
// Assumes div_i and slow_i are register outputs on the same clock.
`timescale 1ns/10ps
module uic_clock_output_pin #(
	parameter int REF_HALF = uic_pkg::UIC_REF_HALF_CYC,
	parameter int SLOW_HALF = uic_pkg::UIC_SLOW_HALF_CYC
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] div_i,
	input wire logic slow_i,
	output logic clk_o
);
	import uic_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic [3:0] div;
		logic slow;
		logic clk;
	} uic_ck_st_t;

	uic_ck_st_t s_q, s_d;
	logic [15:0] half;

	// ************************************************************
	// Divider
	// ************************************************************
	always_comb begin
		s_d = s_q;
		if (s_q.slow) begin
			half = 16'(SLOW_HALF);
		end else begin
			half = 16'((32'(s_q.div) + 32'd1) * 32'(REF_HALF));
		end
		if (s_q.cnt + 16'h0001 >= half) begin
			s_d.cnt = 16'h0000;
			s_d.clk = ~s_q.clk;
			// New setting only at the end of a low phase: no runt pulses
			if (!s_q.clk) begin
				s_d.div = div_i;
				s_d.slow = slow_i;
			end
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s_q <= '{cnt: 16'h0000,
				div: UIC_HWCFG_RST[UIC_HW_DIV_LSB +: 4],
				slow: 1'b0, clk: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign clk_o = s_q.clk;

endmodule : uic_clock_output_pin

// File: src/uic_susp_timer.sv
// Delay from suspend entry to clock stop and slow clock switch.
// Assumes suspended_i is a level on the same clock.
`timescale 1ns/10ps
module uic_susp_timer #(
	parameter int DELAY_CYC = uic_pkg::UIC_SUSP_DELAY_CYC
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic suspended_i,
	output logic expired_o
);
	import uic_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic done;
	} uic_tm_st_t;

	uic_tm_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (!suspended_i) begin
			s_d.cnt = 32'h0000_0000;
			s_d.done = 1'b0;
		end else if (!s_q.done) begin
			if (s_q.cnt + 32'h0000_0001 >= 32'(DELAY_CYC)) begin
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s_q <= '{cnt: 32'h0000_0000, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign expired_o = s_q.done;

endmodule : uic_susp_timer

// File: src/uic_regs.sv
// USB device initialisation and configuration registers.
// Assumes command, data and USB event strobes on sys_clk_i.
`timescale 1ns/10ps
module uic_regs #(
	parameter int SUSP_DELAY_CYC = uic_pkg::UIC_SUSP_DELAY_CYC,
	parameter logic [15:0][10:0] SIZE_LUT = {
		11'd0, 11'd0, 11'd0, 11'd0, 11'd0, 11'd0, 11'd1023, 11'd512,
		11'd256, 11'd128, 11'd64, 11'd32, 11'd16, 11'd8, 11'd0, 11'd0}
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic bus16_i,
	input wire logic cmd_wr_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic data_wr_i,
	input wire logic [15:0] data_i,
	input wire logic data_rd_i,
	output logic [15:0] rd_data_o,
	input wire logic usb_bus_reset_i,
	input wire logic usb_resume_i,
	input wire logic empty_in_ack_i,
	input wire logic ev_ack_i,
	input wire logic ev_iso_done_i,
	input wire logic ev_nak_i,
	input wire logic ev_err_i,
	input wire logic otg_mode_i,
	input wire logic otg_local_connect_i,
	output logic [15:0] endpoint_enable_o,
	output logic [15:0] endpoint_direction_o,
	output logic [15:0] double_buffer_enable_o,
	output logic [15:0] isochronous_select_o,
	output logic buffers_invalid_o,
	output logic alloc_busy_o,
	output logic alloc_done_o,
	output logic [15:0] alloc_total_o,
	output logic [6:0] usb_device_addr_o,
	output logic device_enable_o,
	output logic suspended_o,
	output logic clocks_stopped_o,
	output logic irq_o,
	output logic port1_dplus_pullup_o,
	output logic clock_output_pin_o
);
	import uic_pkg::*;

	typedef struct packed {
		logic [15:0][7:0] ep;
		logic [7:0] addr;
		logic [7:0] mode;
		logic [15:0] hw;
		logic [7:0] cmd;
		logic hi_byte;
		logic [4:0] seq;
		uic_alloc_st_t al;
		logic [3:0] al_idx;
		logic [15:0] al_sum;
		logic al_done;
		logic inval;
		logic [6:0] act_addr;
		logic act_en;
		logic addr_pend;
		logic susp;
		logic [15:0] rdata;
		logic irq;
	} uic_st_t;

	uic_st_t s_q, s_d;
	logic susp_expired;
	logic [15:0] ep_bytes;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic is_ep_cmd(input logic [7:0] c,
		input logic [7:0] base);
		is_ep_cmd = (c[7:4] == base[7:4]);
	endfunction : is_ep_cmd

	function automatic logic [15:0] ep_size(input logic [7:0] cfg);
		logic [15:0] b;
		b = {5'h00, SIZE_LUT[cfg[3:0]]};
		if (!cfg[UIC_EP_BUF_EN]) begin
			ep_size = 16'h0000;
		end else if (cfg[UIC_EP_DBL]) begin
			ep_size = {b[14:0], 1'b0};
		end else begin
			ep_size = b;
		end
	endfunction : ep_size

	function automatic logic alloc_change(input logic [7:0] o,
		input logic [7:0] n);
		alloc_change = (o[UIC_EP_BUF_EN] != n[UIC_EP_BUF_EN]) ||
			(o[UIC_EP_DBL] != n[UIC_EP_DBL]) ||
			(o[3:0] != n[3:0]);
	endfunction : alloc_change

	assign ep_bytes = ep_size(s_q.ep[s_q.al_idx]);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.inval = 1'b0;
		s_d.al_done = 1'b0;
		if (cmd_wr_i) begin
			s_d.cmd = cmd_code_i;
			s_d.hi_byte = 1'b0;
		end
		// Clears come first so that a write in the same cycle wins
		// Deferred address switch
		if (s_q.addr_pend && empty_in_ack_i) begin
			s_d.act_addr = s_q.addr[6:0];
			s_d.act_en = s_q.addr[UIC_ADDR_DEV_EN];
			s_d.addr_pend = 1'b0;
		end
		if (usb_resume_i) begin
			s_d.susp = 1'b0;
		end
		// Register writes
		if (data_wr_i && !cmd_wr_i) begin
			if (is_ep_cmd(s_q.cmd, UIC_CMD_EPCFG_WR)) begin
				s_d.ep[s_q.cmd[3:0]] = data_i[7:0];
				if (alloc_change(s_q.ep[s_q.cmd[3:0]], data_i[7:0])) begin
					s_d.inval = 1'b1;
				end
				// Track the in-order walk from control OUT upward
				if ({1'b0, s_q.cmd[3:0]} == s_q.seq) begin
					s_d.seq = s_q.seq + 5'h01;
				end else if (s_q.cmd[3:0] == 4'h0) begin
					s_d.seq = 5'h01;
				end else begin
					s_d.seq = 5'h00;
				end
				if (s_q.cmd[3:0] == UIC_LAST_EP &&
					s_q.seq == {1'b0, UIC_LAST_EP}) begin
					s_d.al = UIC_AL_RUN;
					s_d.al_idx = 4'h0;
					s_d.al_sum = 16'h0000;
					s_d.seq = 5'h00;
				end
			end else if (s_q.cmd == UIC_CMD_ADDR_WR) begin
				s_d.addr = data_i[7:0];
				s_d.addr_pend = 1'b1;
			end else if (s_q.cmd == UIC_CMD_MODE_WR) begin
				// Only the low byte counts, even on a 16-bit bus
				s_d.mode = data_i[7:0] & UIC_MODE_WMASK;
				if (s_q.mode[UIC_MODE_SUSP] && !data_i[UIC_MODE_SUSP]) begin
					s_d.susp = 1'b1;
				end
			end else if (s_q.cmd == UIC_CMD_HWCFG_WR) begin
				if (bus16_i) begin
					s_d.hw = data_i & UIC_HWCFG_WMASK;
				end else if (!s_q.hi_byte) begin
					s_d.hw[7:0] = data_i[7:0] & UIC_HWCFG_WMASK[7:0];
					s_d.hi_byte = 1'b1;
				end else begin
					s_d.hw[15:8] = data_i[7:0] & UIC_HWCFG_WMASK[15:8];
					s_d.hi_byte = 1'b0;
				end
			end
		end
		// Register reads
		if (data_rd_i && !cmd_wr_i) begin
			if (is_ep_cmd(s_q.cmd, UIC_CMD_EPCFG_RD)) begin
				s_d.rdata = {8'h00, s_q.ep[s_q.cmd[3:0]]};
			end else if (s_q.cmd == UIC_CMD_ADDR_RD) begin
				s_d.rdata = {8'h00, s_q.addr};
			end else if (s_q.cmd == UIC_CMD_MODE_RD) begin
				s_d.rdata = {8'h00, s_q.mode};
			end else if (s_q.cmd == UIC_CMD_HWCFG_RD) begin
				if (bus16_i) begin
					s_d.rdata = s_q.hw;
				end else begin
					s_d.rdata = {8'h00, s_q.hi_byte ? s_q.hw[15:8] :
						s_q.hw[7:0]};
					s_d.hi_byte = ~s_q.hi_byte;
				end
			end else begin
				s_d.rdata = 16'h0000;
			end
		end
		// Buffer allocation walk, one endpoint per cycle
		case (s_q.al)
			UIC_AL_IDLE: begin
			end
			UIC_AL_RUN: begin
				s_d.al_sum = s_q.al_sum + ep_bytes;
				s_d.al_idx = s_q.al_idx + 4'h1;
				if (s_q.al_idx == UIC_LAST_EP) begin
					s_d.al = UIC_AL_IDLE;
					s_d.al_done = 1'b1;
				end
			end
			default: begin
				s_d.al = UIC_AL_IDLE;
			end
		endcase
		// Bus reset overrides; mode and hardware config are kept
		if (usb_bus_reset_i) begin
			for (int i = 0; i < UIC_NUM_EP; i++) begin
				s_d.ep[i][UIC_EP_BUF_EN] = 1'b0;
				if (s_q.ep[i][UIC_EP_BUF_EN]) begin
					s_d.inval = 1'b1;
				end
			end
			s_d.act_addr = 7'h00;
			s_d.act_en = 1'b1;
			s_d.addr_pend = 1'b0;
			s_d.al = UIC_AL_IDLE;
			s_d.seq = 5'h00;
			s_d.susp = 1'b0;
		end
		// Interrupt source selection
		if (s_q.mode[UIC_MODE_DBG]) begin
			s_d.irq = s_q.mode[UIC_MODE_GIE] &&
				(ev_nak_i || ev_err_i);
		end else begin
			s_d.irq = s_q.mode[UIC_MODE_GIE] &&
				(ev_ack_i || ev_iso_done_i);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s_q.ep <= {UIC_NUM_EP{UIC_EPCFG_RST}};
			s_q.addr <= UIC_ADDR_RST;
			s_q.mode <= UIC_MODE_RST;
			s_q.hw <= UIC_HWCFG_RST;
			s_q.cmd <= 8'h00;
			s_q.hi_byte <= 1'b0;
			s_q.seq <= 5'h00;
			s_q.al <= UIC_AL_IDLE;
			s_q.al_idx <= 4'h0;
			s_q.al_sum <= 16'h0000;
			s_q.al_done <= 1'b0;
			s_q.inval <= 1'b0;
			s_q.act_addr <= 7'h00;
			s_q.act_en <= 1'b0;
			s_q.addr_pend <= 1'b0;
			s_q.susp <= 1'b0;
			s_q.rdata <= 16'h0000;
			s_q.irq <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Suspend timing and clock pin
	// ************************************************************
	uic_susp_timer #(
		.DELAY_CYC(SUSP_DELAY_CYC)
	) u_timer (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.suspended_i(s_q.susp),
		.expired_o(susp_expired)
	);

	uic_clock_output_pin u_clock_output_pin (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.div_i(s_q.hw[UIC_HW_DIV_LSB +: 4]),
		.slow_i(susp_expired && !s_q.hw[UIC_HW_NO_SLOW]),
		.clk_o(clock_output_pin_o)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	// Clock stop is a request to the oscillator/PLL, which lives elsewhere
	assign clocks_stopped_o = susp_expired &&
		!s_q.hw[UIC_HW_CLK_ON];

	// OTG mode hands the pull-up to the OTG control register
	assign port1_dplus_pullup_o = otg_mode_i ? otg_local_connect_i :
		(!s_q.hw[UIC_HW_EXT_PULL] && s_q.mode[UIC_MODE_PULLUP]);

	genvar g;
	generate
		for (g = 0; g < UIC_NUM_EP; g++) begin : g_ep
			assign endpoint_enable_o[g] = s_q.ep[g][UIC_EP_BUF_EN];
			assign endpoint_direction_o[g] = s_q.ep[g][UIC_EP_DIR];
			assign double_buffer_enable_o[g] = s_q.ep[g][UIC_EP_DBL];
			assign isochronous_select_o[g] = s_q.ep[g][UIC_EP_ISO];
		end
	endgenerate

	assign rd_data_o = s_q.rdata;
	assign buffers_invalid_o = s_q.inval;
	assign alloc_busy_o = (s_q.al == UIC_AL_RUN);
	assign alloc_done_o = s_q.al_done;
	assign alloc_total_o = s_q.al_sum;
	assign usb_device_addr_o = s_q.act_addr;
	assign device_enable_o = s_q.act_en;
	assign suspended_o = s_q.susp;
	assign irq_o = s_q.irq;

endmodule : uic_regs

// File: test/uic_cpu_model.sv
// Processor model that drives the command and data strobes.
// Assumes one clock; every request changes just after a rising edge.
`timescale 1ns/10ps
module uic_cpu_model (
	input wire logic sys_clk_i,
	input wire logic [15:0] rd_data_i,
	output logic cmd_wr_o,
	output logic [7:0] cmd_code_o,
	output logic data_wr_o,
	output logic [15:0] data_o,
	output logic data_rd_o
);
	// ************************************************************
	// Access tasks
	// ************************************************************
	initial begin
		cmd_wr_o = 1'b0;
		cmd_code_o = 8'h00;
		data_wr_o = 1'b0;
		data_o = 16'h0000;
		data_rd_o = 1'b0;
	end

	task cmd(input logic [7:0] c);
		@(posedge sys_clk_i);
		cmd_wr_o <= 1'b1;
		cmd_code_o <= c;
		@(posedge sys_clk_i);
		cmd_wr_o <= 1'b0;
	endtask : cmd

	// Released data shows the inverse so a stale value cannot pass
	task wr(input logic [15:0] d);
		@(posedge sys_clk_i);
		data_wr_o <= 1'b1;
		data_o <= d;
		@(posedge sys_clk_i);
		data_wr_o <= 1'b0;
		data_o <= ~d;
	endtask : wr

	task rd(output logic [15:0] q);
		@(posedge sys_clk_i);
		data_rd_o <= 1'b1;
		@(posedge sys_clk_i);
		data_rd_o <= 1'b0;
		#1;
		q = rd_data_i;
	endtask : rd
endmodule : uic_cpu_model

// File: test/uic_regs_monitor.sv
// Concurrent checks on the ports of the configuration register block.
// Assumes one clock domain with a synchronous active high reset.
`timescale 1ns/10ps
module uic_regs_monitor (
	input logic sys_clk_i,
	input logic reset_i,
	input logic data_wr_i,
	input logic data_rd_i,
	input logic [15:0] rd_data_o,
	input logic usb_bus_reset_i,
	input logic empty_in_ack_i,
	input logic ev_ack_i,
	input logic ev_iso_done_i,
	input logic ev_nak_i,
	input logic ev_err_i,
	input logic otg_mode_i,
	input logic otg_local_connect_i,
	input logic [15:0] endpoint_enable_o,
	input logic buffers_invalid_o,
	input logic alloc_busy_o,
	input logic alloc_done_o,
	input logic [6:0] usb_device_addr_o,
	input logic device_enable_o,
	input logic suspended_o,
	input logic clocks_stopped_o,
	input logic irq_o,
	input logic port1_dplus_pullup_o
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	property p_ep_rst; usb_bus_reset_i |=> endpoint_enable_o == 16'h0000;
	endproperty
	a_ep_rst: assert property (p_ep_rst) else $error("ep kept");
	property p_adr_rst;
		usb_bus_reset_i |=> device_enable_o && usb_device_addr_o == 7'h00;
	endproperty
	a_adr_rst: assert property (p_adr_rst) else $error("addr rst");
	property p_adr_hold; $changed(usb_device_addr_o) |->
		$past(empty_in_ack_i) || $past(usb_bus_reset_i); endproperty
	a_adr_hold: assert property (p_adr_hold) else $error("addr");
	property p_irq; irq_o |-> $past(ev_ack_i) || $past(ev_iso_done_i) ||
		$past(ev_nak_i) || $past(ev_err_i); endproperty
	a_irq: assert property (p_irq) else $error("irq cause");
	// Walk covers all sixteen endpoints, one per cycle
	property p_alloc; $rose(alloc_busy_o) |-> alloc_busy_o[*8] ##1
		alloc_busy_o[*8] ##1 (alloc_done_o && !alloc_busy_o); endproperty
	a_alloc: assert property (p_alloc) else $error("alloc walk");
	property p_susp; $rose(suspended_o) |-> $past(data_wr_i); endproperty
	a_susp: assert property (p_susp) else $error("suspend");
	property p_stop; $rose(clocks_stopped_o) |->
		suspended_o && $past(suspended_o, 40); endproperty
	a_stop: assert property (p_stop) else $error("clock stop");
	property p_otg; otg_mode_i |->
		port1_dplus_pullup_o == otg_local_connect_i; endproperty
	a_otg: assert property (p_otg) else $error("otg pullup");
	// Bus reset drops enabled endpoints and so invalidates buffers too
	property p_inval; buffers_invalid_o |->
		$past(data_wr_i) || $past(usb_bus_reset_i); endproperty
	a_inval: assert property (p_inval) else $error("invalid");
	property p_rd; $changed(rd_data_o) |-> $past(data_rd_i); endproperty
	a_rd: assert property (p_rd) else $error("read data");
endmodule : uic_regs_monitor

bind uic_regs uic_regs_monitor i_uic_regs_monitor (.*);

// File: test/uic_regs_bench.sv
// Self-checking bench for the configuration register block.
// Assumes the processor model and the bound monitor are compiled.
`timescale 1ns/10ps
module uic_regs_bench;
	import uic_pkg::*;
	logic sys_clk_i = 1'b0, reset_i = 1'b1, bus16_i = 1'b1;
	logic otg_mode_i = 1'b0, otg_local_connect_i = 1'b0;
	logic cmd_wr_i, data_wr_i, data_rd_i, usb_bus_reset_i, usb_resume_i;
	logic empty_in_ack_i, ev_ack_i, ev_iso_done_i, ev_nak_i, ev_err_i;
	logic buffers_invalid_o, alloc_busy_o, alloc_done_o, device_enable_o;
	logic suspended_o, clocks_stopped_o, irq_o, port1_dplus_pullup_o;
	logic clock_output_pin_o, b;
	logic [7:0] cmd_code_i, m;
	logic [6:0] usb_device_addr_o, ev = 7'h00;
	logic [15:0] data_i, rd_data_o, alloc_total_o, q;
	logic [15:0] endpoint_enable_o, endpoint_direction_o;
	logic [15:0] double_buffer_enable_o, isochronous_select_o;
	logic [7:0] modes [3] = '{8'h08, 8'h0C, 8'h04};
	int n_fail = 0, checked = 0, n;

	always #2.5 sys_clk_i = ~sys_clk_i;
	assign {empty_in_ack_i, usb_resume_i, usb_bus_reset_i, ev_err_i,
		ev_nak_i, ev_iso_done_i, ev_ack_i} = ev;

	uic_cpu_model i_uic_cpu_model (.sys_clk_i(sys_clk_i),
		.rd_data_i(rd_data_o), .cmd_wr_o(cmd_wr_i),
		.cmd_code_o(cmd_code_i), .data_wr_o(data_wr_i), .data_o(data_i),
		.data_rd_o(data_rd_i));
	// Short suspend delay keeps the run brief
	uic_regs #(.SUSP_DELAY_CYC(50)) i_uic_regs (.*);

	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [7:0] cfg(input int i);
		return {i != 15, i[0], i[1], i[2], 4'h2};
	endfunction : cfg

	task test_done;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wreg(input logic [7:0] c, input logic [15:0] d);
		i_uic_cpu_model.cmd(c);
		i_uic_cpu_model.wr(d);
		#1;
	endtask : wreg

	task rchk(input logic [7:0] c, input logic [15:0] e);
		i_uic_cpu_model.cmd(c);
		i_uic_cpu_model.rd(q);
		chk(q, e);
	endtask : rchk

	task pulse(input int sel);
		@(posedge sys_clk_i);
		ev <= 7'h01 << sel;
		@(posedge sys_clk_i);
		ev <= 7'h00;
		#1;
	endtask : pulse

	task poll(input int sel);
		for (n = 0; n < 64; n++) begin
			@(posedge sys_clk_i);
			#1;
			if ((sel ? clocks_stopped_o : alloc_done_o) === 1'b1) return;
		end
		n_fail++;
		$display("BAD t=%0t wait=%h got=%h", $time, sel, 1'b0);
		test_done();
	endtask : poll

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rchk(UIC_CMD_MODE_RD, {8'h00, UIC_MODE_RST});
		rchk(UIC_CMD_HWCFG_RD, UIC_HWCFG_RST);
		rchk(UIC_CMD_ADDR_RD, 16'h0000);
		rchk(8'h3F, 16'h0000);
		rchk(8'hC5, 16'h0000);
		q = 16'h0000;
		m[0] = clock_output_pin_o;
		repeat (64) begin
			@(posedge sys_clk_i);
			#1;
			q += {15'h0, clock_output_pin_o ^ m[0]};
			m[0] = clock_output_pin_o;
		end
		chk(q, 16'(64 / (4 * UIC_REF_HALF_CYC)));
		$display("reset test done");
		wreg(UIC_CMD_MODE_WR, 16'hFF01);
		rchk(UIC_CMD_MODE_RD, 16'h0001);
		chk({15'h0, port1_dplus_pullup_o}, 16'h0001);
		for (n = 0; n < 2; n++) begin
			@(posedge sys_clk_i);
			otg_mode_i <= 1'b1;
			otg_local_connect_i <= n[0];
			#1;
			chk({15'h0, port1_dplus_pullup_o}, 16'(n));
		end
		@(posedge sys_clk_i);
		otg_mode_i <= 1'b0;
		wreg(UIC_CMD_ADDR_WR, 16'h0085);
		chk({8'h00, device_enable_o, usb_device_addr_o}, 16'h0000);
		pulse(6);
		chk({8'h00, device_enable_o, usb_device_addr_o}, 16'h0085);
		$display("address test done");
		// Nothing buffered yet, so there is no data to drain first
		for (int i = 0; i < 16; i++)
			wreg(UIC_CMD_EPCFG_WR + 8'(i), {8'h00, cfg(i)});
		poll(0);
		chk(alloc_total_o, 16'd176);
		chk(endpoint_enable_o, 16'h7FFF);
		chk(endpoint_direction_o, 16'hAAAA);
		chk(double_buffer_enable_o, 16'hCCCC);
		chk(isochronous_select_o, 16'hF0F0);
		rchk(8'h3E, {8'h00, cfg(14)});
		wreg(8'h2E, {8'h00, cfg(14) ^ 8'h01});
		chk({15'h0, buffers_invalid_o}, 16'h0001);
		$display("endpoint test done");
		wreg(UIC_CMD_MODE_WR, 16'h000D);
		wreg(UIC_CMD_HWCFG_WR, 16'h5A5A);
		chk({15'h0, port1_dplus_pullup_o}, 16'h0000);
		pulse(4);
		chk(endpoint_enable_o, 16'h0000);
		chk({8'h00, device_enable_o, usb_device_addr_o}, 16'h0080);
		rchk(UIC_CMD_ADDR_RD, 16'h0085);
		rchk(UIC_CMD_MODE_RD, 16'h000D);
		rchk(UIC_CMD_HWCFG_RD, 16'h5A5A & UIC_HWCFG_WMASK);
		rchk(8'h3E, {8'h00, cfg(14) ^ 8'h81});
		$display("bus reset test done");
		foreach (modes[k]) begin
			wreg(UIC_CMD_MODE_WR, {8'h00, modes[k]});
			for (int e = 0; e < 4; e++) begin
				pulse(e);
				b = modes[k][3] & (modes[k][2] ? e > 1 : e < 2);
				chk({15'h0, irq_o}, {15'h0, b});
			end
		end
		$display("interrupt test done");
		wreg(UIC_CMD_MODE_WR, 16'h0028);
		chk({15'h0, suspended_o}, 16'h0000);
		wreg(UIC_CMD_MODE_WR, 16'h0008);
		chk({15'h0, suspended_o}, 16'h0001);
		repeat (60) @(posedge sys_clk_i);
		#1;
		chk({15'h0, clocks_stopped_o}, 16'h0000);
		pulse(5);
		chk({15'h0, suspended_o}, 16'h0000);
		@(posedge sys_clk_i);
		bus16_i <= 1'b0;
		i_uic_cpu_model.cmd(UIC_CMD_HWCFG_WR);
		i_uic_cpu_model.wr(16'hA544);
		i_uic_cpu_model.wr(16'h5A03);
		i_uic_cpu_model.cmd(UIC_CMD_HWCFG_RD);
		i_uic_cpu_model.rd(q);
		chk(q, {8'h00, 8'h44 & UIC_HWCFG_WMASK[7:0]});
		i_uic_cpu_model.rd(q);
		chk(q, {8'h00, 8'h03 & UIC_HWCFG_WMASK[15:8]});
		wreg(UIC_CMD_MODE_WR, 16'h0028);
		wreg(UIC_CMD_MODE_WR, 16'h0008);
		repeat (40) @(posedge sys_clk_i);
		#1;
		chk({15'h0, clocks_stopped_o}, 16'h0000);
		poll(1);
		chk({15'h0, clocks_stopped_o}, 16'h0001);
		$display("suspend test done");
		test_done();
	end
endmodule : uic_regs_bench
